// ===== hdl/fsw_defines.vh
// Purpose: constants for the status word and write-protect logic
// Assumes: 21-bit byte address, 16-bit status word
// Notes: cycle counts are at the 50 MHz system clock
`ifndef FSW_DEFINES_VH
`define FSW_DEFINES_VH

// ==========================================
// command codes
`define FSW_CMD_WREN 8'h06
`define FSW_CMD_WRDI 8'h04
`define FSW_CMD_RDSR_LO 8'h05
`define FSW_CMD_RDSR_HI 8'h35
`define FSW_CMD_SRW 8'h01
`define FSW_CMD_PP 8'h02
`define FSW_CMD_SE 8'h20
`define FSW_CMD_BE32 8'h52
`define FSW_CMD_BE64 8'hd8
`define FSW_CMD_CE_A 8'h60
`define FSW_CMD_CE_B 8'hc7
`define FSW_CMD_SUSPEND 8'h75
`define FSW_CMD_RESUME 8'h7a
`define FSW_CMD_HPM 8'ha3
`define FSW_CMD_HPM_EXIT 8'hab

// ==========================================
// status word bit positions
`define FSW_BIT_BUSY 0
`define FSW_BIT_WEL 1
`define FSW_BIT_BP_LSB 2
`define FSW_BIT_BP_MSB 6
`define FSW_BIT_PM_LO 7
`define FSW_BIT_PM_HI 8
`define FSW_BIT_QE 9
`define FSW_BIT_LB 10
`define FSW_BIT_HPF 13
`define FSW_BIT_CMP 14
`define FSW_BIT_SUS 15

// ==========================================
// power-up values of non-volatile fields
`define FSW_RST_BP 5'h00
`define FSW_RST_QE 1'b0
`define FSW_RST_LB 1'b0
`define FSW_RST_CMP 1'b0
`define FSW_RST_PM_LO 1'b0

// ==========================================
// address geometry
`define FSW_ADDR_W 21
`define FSW_PAGE_LAST 21'h0000ff
`define FSW_SECTOR_LAST 21'h000fff
`define FSW_BLK32_LAST 21'h007fff
`define FSW_BLK64_LAST 21'h00ffff

// ==========================================
// busy times in system clock cycles
`define FSW_SRW_CYCLES 24'h000400
`define FSW_PP_CYCLES 24'h000800
`define FSW_SE_CYCLES 24'h001000
`define FSW_BE_CYCLES 24'h004000
`define FSW_CE_CYCLES 24'h010000

// ==========================================
// array operation codes
`define FSW_OP_PROG 2'h0
`define FSW_OP_SECT 2'h1
`define FSW_OP_BLK 2'h2
`define FSW_OP_CHIP 2'h3

`endif

// ===== hdl/fsw_protect.v
// Function
// - complement set with low protect code zero protects the whole array
// - complement, bp4 and bp3 low: codes 1 to 5 protect a lower region
// - complement, bp4 low, bp3 high: codes 1 to 5 protect an upper region
// - complement set with protect bits 2 and 1 high leaves nothing protected
// - complement, bp4 high, bp3 low: all below the top 4K to 32K protected
// - complement, bp4 and bp3 high: all above the bottom 4K to 32K protected
// - 16-bit status word with suspend, complement, hpf, lock, quad, mode-hi in upper byte
// - busy flag is one exactly while program, erase or status write runs
// - latch cleared refuses status write, program, erase; flag shows latch
// - block-protect bits change only by status write outside hardware lock
// - program, sector and block erase into the protected region are refused
// - chip erase runs only with protect bits 2..0 zero and complement zero
// - protect mode 00: status word writable once latch set, pin ignored
// - protect mode 01 with write-protect pin low locks the status word while quad enable is zero
// - protect mode 01 with pin high: writable once latch set
// - protect mode 10 locks until power cycle, which restores mode 00
// - protect mode 11 locks the status word until power cycle, which restores mode 00
// - quad enable is a read/write status bit gating quad transfers
// - latch set by write enable, cleared by power-up, disable, writes, erases
// - complement bit is read/write at bit 14, default zero
// - security lock defaults zero and once set clears only at power-up
// - suspend flag read-only, set by suspend, cleared by resume or power cycle
//
// Purpose: status word, write-enable latch and array protection of a serial flash
// Assumes: spi pins sampled by clock_i, mode 0 or 3, sclk well below clock_i / 4
// Notes: array itself lives outside; array_go_o starts an accepted operation
`timescale 1ns/1ps
`include "fsw_defines.vh"

module fsw_protect
#(
  parameter [23:0] SRW_CYCLES = `FSW_SRW_CYCLES,
  parameter [23:0] PP_CYCLES = `FSW_PP_CYCLES,
  parameter [23:0] SE_CYCLES = `FSW_SE_CYCLES,
  parameter [23:0] BE_CYCLES = `FSW_BE_CYCLES,
  parameter [23:0] CE_CYCLES = `FSW_CE_CYCLES
)
(
  input wire clock_i,
  input wire arst_n_i,
  input wire sclk_i,
  input wire cs_n_i,
  input wire si_i,
  input wire wp_n_i,
  output wire so_o,
  output wire so_oe_o,
  output wire [15:0] status_o,
  output wire busy_flag_o,
  output wire write_enable_latch_o,
  output wire quad_enable_o,
  output wire security_lock_o,
  output wire array_go_o,
  output wire [1:0] array_op_o,
  output wire [20:0] array_addr_o
);

  // ==========================================
  // reset release and pin synchronisers
  reg [1:0] rst_sync_r;
  wire rst_n;
  reg [1:0] sclk_sync_r;
  reg [1:0] cs_sync_r;
  reg [1:0] si_sync_r;
  reg [1:0] wp_sync_r;
  reg sclk_d_r;
  reg cs_d_r;

  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_sync_r <= 2'b00;
      cs_sync_r <= 2'b11;
      si_sync_r <= 2'b00;
      wp_sync_r <= 2'b11;
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end
    else
    begin
      sclk_sync_r <= {sclk_sync_r[0], sclk_i};
      cs_sync_r <= {cs_sync_r[0], cs_n_i};
      si_sync_r <= {si_sync_r[0], si_i};
      wp_sync_r <= {wp_sync_r[0], wp_n_i};
      sclk_d_r <= sclk_sync_r[1];
      cs_d_r <= cs_sync_r[1];
    end
  end

  wire sclk_s = sclk_sync_r[1];
  wire cs_s = cs_sync_r[1];
  wire sclk_rise = sclk_s & !sclk_d_r & !cs_s;
  wire sclk_fall = !sclk_s & sclk_d_r & !cs_s;
  wire deselect = cs_s & !cs_d_r;

  // ==========================================
  // status fields
  reg [4:0] bp_r;
  reg pm_lo_r;
  reg pm_hi_r;
  reg qe_r;
  reg lb_r;
  reg cmp_r;
  reg hpf_r;
  reg sus_r;
  reg wel_r;
  reg run_r;
  reg [23:0] busy_cnt_r;
  reg [1:0] run_op_r;
  reg run_srw_r;

  wire busy = run_r & !sus_r;
  assign status_o = {sus_r, cmp_r, hpf_r, 2'b00, lb_r, qe_r, pm_hi_r,
                     pm_lo_r, bp_r, wel_r, busy};
  assign busy_flag_o = busy;
  assign write_enable_latch_o = wel_r;
  assign quad_enable_o = qe_r;
  assign security_lock_o = lb_r;

  // ==========================================
  // serial shifter
  reg [2:0] bit_cnt_r;
  reg [7:0] shift_r;
  reg [7:0] cmd_r;
  reg [2:0] byte_cnt_r;
  reg [20:0] addr_r;
  reg [7:0] srw_lo_r;
  reg [7:0] srw_hi_r;
  reg [7:0] out_sh_r;
  reg so_r;
  wire [7:0] shift_nxt = {shift_r[6:0], si_sync_r[1]};
  wire byte_done = sclk_rise & (bit_cnt_r == 3'h7);

  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      cmd_r <= 8'h00;
      byte_cnt_r <= 3'h0;
      addr_r <= 21'h000000;
      srw_lo_r <= 8'h00;
      srw_hi_r <= 8'h00;
    end
    else if (cs_s)
    begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
    end
    else if (sclk_rise)
    begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      shift_r <= shift_nxt;
      if (byte_done)
      begin
        if (byte_cnt_r != 3'h7)
          byte_cnt_r <= byte_cnt_r + 3'h1;
        case (byte_cnt_r)
          3'h0: cmd_r <= shift_nxt;
          3'h1:
          begin
            srw_lo_r <= shift_nxt;
            addr_r[20:16] <= shift_nxt[4:0];
          end
          3'h2:
          begin
            srw_hi_r <= shift_nxt;
            addr_r[15:8] <= shift_nxt;
          end
          3'h3: addr_r[7:0] <= shift_nxt;
          default: addr_r <= addr_r;
        endcase
      end
    end
  end

  // ==========================================
  // status read path, shifted on falling sclk
  wire reading = (byte_cnt_r != 3'h0) &&
                 ((cmd_r == `FSW_CMD_RDSR_LO) || (cmd_r == `FSW_CMD_RDSR_HI));
  wire [7:0] rd_byte = (cmd_r == `FSW_CMD_RDSR_HI) ? status_o[15:8] : status_o[7:0];

  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_sh_r <= 8'h00;
      so_r <= 1'b0;
    end
    else if (sclk_fall && reading)
    begin
      // status sampled fresh each byte so busy polling sees live state
      if (bit_cnt_r == 3'h0)
      begin
        so_r <= rd_byte[7];
        out_sh_r <= {rd_byte[6:0], 1'b0};
      end
      else
      begin
        so_r <= out_sh_r[7];
        out_sh_r <= {out_sh_r[6:0], 1'b0};
      end
    end
  end

  assign so_o = so_r;
  assign so_oe_o = reading & !cs_s;

  // ==========================================
  // protection of the target span
  reg [20:0] span_last;
  wire prot_first;
  wire prot_last;

  always @*
  begin
    case (cmd_r)
      `FSW_CMD_PP: span_last = addr_r | `FSW_PAGE_LAST;
      `FSW_CMD_SE: span_last = addr_r | `FSW_SECTOR_LAST;
      `FSW_CMD_BE32: span_last = addr_r | `FSW_BLK32_LAST;
      `FSW_CMD_BE64: span_last = addr_r | `FSW_BLK64_LAST;
      default: span_last = addr_r;
    endcase
  end

  // region sits at an array end, so checking both span ends is enough
  fsw_range_check u_chk_first
  (
    .addr_i(addr_r),
    .bp_i(bp_r),
    .cmp_i(cmp_r),
    .prot_o(prot_first)
  );

  fsw_range_check u_chk_last
  (
    .addr_i(span_last),
    .bp_i(bp_r),
    .cmp_i(cmp_r),
    .prot_o(prot_last)
  );

  wire span_prot = prot_first | prot_last;
  wire chip_ok = (bp_r[2:0] == 3'b000) & !cmp_r;

  // ==========================================
  // command execution at deselect
  wire framed = deselect & (bit_cnt_r == 3'h0);
  wire is_pp = (cmd_r == `FSW_CMD_PP) && (byte_cnt_r >= 3'h5);
  wire is_se = (cmd_r == `FSW_CMD_SE) && (byte_cnt_r == 3'h4);
  wire is_be = ((cmd_r == `FSW_CMD_BE32) || (cmd_r == `FSW_CMD_BE64)) && (byte_cnt_r == 3'h4);
  wire is_ce = ((cmd_r == `FSW_CMD_CE_A) || (cmd_r == `FSW_CMD_CE_B)) && (byte_cnt_r == 3'h1);
  wire is_srw = (cmd_r == `FSW_CMD_SRW) && ((byte_cnt_r == 3'h2) || (byte_cnt_r == 3'h3));
  wire is_one = (byte_cnt_r == 3'h1);
  // quad mode turns the protect pin into a data line, so it stops locking
  wire hw_lock = pm_lo_r & !pm_hi_r & !wp_sync_r[1] & !qe_r;
  wire sr_lock = pm_hi_r | hw_lock;
  wire write_cmd = is_pp | is_se | is_be | is_ce | is_srw;
  wire idle = !run_r;
  wire arr_ok = wel_r & ((is_pp | is_se | is_be) ? !span_prot : chip_ok);
  wire arr_go = framed & idle & (is_pp | is_se | is_be | is_ce) & arr_ok;
  wire srw_go = framed & idle & is_srw & wel_r & !sr_lock;

  wire [1:0] op_nxt = is_se ? `FSW_OP_SECT : is_be ? `FSW_OP_BLK : is_ce ? `FSW_OP_CHIP : `FSW_OP_PROG;
  wire [23:0] load_cnt = is_se ? SE_CYCLES : is_be ? BE_CYCLES : is_ce ? CE_CYCLES : PP_CYCLES;

  reg go_r;
  reg [1:0] go_op_r;
  reg [20:0] go_addr_r;

  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // power-up: mode 10 falls back to 00, volatile flags clear
      bp_r <= `FSW_RST_BP;
      pm_lo_r <= `FSW_RST_PM_LO;
      pm_hi_r <= 1'b0;
      qe_r <= `FSW_RST_QE;
      lb_r <= `FSW_RST_LB;
      cmp_r <= `FSW_RST_CMP;
      hpf_r <= 1'b0;
      sus_r <= 1'b0;
      wel_r <= 1'b0;
      run_r <= 1'b0;
      run_srw_r <= 1'b0;
      run_op_r <= `FSW_OP_PROG;
      busy_cnt_r <= 24'h000000;
      go_r <= 1'b0;
      go_op_r <= `FSW_OP_PROG;
      go_addr_r <= 21'h000000;
    end
    else
    begin
      go_r <= arr_go;
      if (run_r && !sus_r)
      begin
        if (busy_cnt_r <= 24'h000001)
        begin
          run_r <= 1'b0;
          run_srw_r <= 1'b0;
        end
        else
          busy_cnt_r <= busy_cnt_r - 24'h000001;
      end
      if (framed && idle)
      begin
        if (is_one && (cmd_r == `FSW_CMD_WREN))
          wel_r <= 1'b1;
        else if ((is_one && (cmd_r == `FSW_CMD_WRDI)) || write_cmd)
          wel_r <= 1'b0;
        if (is_one && (cmd_r == `FSW_CMD_HPM))
          hpf_r <= 1'b1;
        else if (is_one && (cmd_r == `FSW_CMD_HPM_EXIT))
          hpf_r <= 1'b0;
      end
      if (srw_go)
      begin
        bp_r <= srw_lo_r[`FSW_BIT_BP_MSB:`FSW_BIT_BP_LSB];
        pm_lo_r <= srw_lo_r[`FSW_BIT_PM_LO];
        if (byte_cnt_r == 3'h3)
        begin
          pm_hi_r <= srw_hi_r[0];
          qe_r <= srw_hi_r[1];
          lb_r <= lb_r | srw_hi_r[2];
          cmp_r <= srw_hi_r[6];
        end
        run_r <= 1'b1;
        run_srw_r <= 1'b1;
        busy_cnt_r <= SRW_CYCLES;
      end
      else if (arr_go)
      begin
        run_r <= 1'b1;
        run_op_r <= op_nxt;
        busy_cnt_r <= load_cnt;
        go_op_r <= op_nxt;
        go_addr_r <= addr_r;
      end
      // suspend only applies to a running array operation
      if (framed && is_one && (cmd_r == `FSW_CMD_SUSPEND) && run_r && !run_srw_r && (run_op_r != `FSW_OP_CHIP))
        sus_r <= 1'b1;
      else if (framed && is_one && (cmd_r == `FSW_CMD_RESUME))
        sus_r <= 1'b0;
    end
  end

  assign array_go_o = go_r;
  assign array_op_o = go_op_r;
  assign array_addr_o = go_addr_r;

endmodule // fsw_protect

// ===== hdl/fsw_range_check.v
// Purpose: tells whether one byte address lies in the protected region
// Assumes: 2M array, block-protect field plus complement bit
// Notes: one instance per end of a target span
`timescale 1ns/1ps
`include "fsw_defines.vh"

module fsw_range_check
(
  input wire [20:0] addr_i,
  input wire [4:0] bp_i,
  input wire cmp_i,
  output wire prot_o
);

  // ==========================================
  // region size as a power of two
  wire [2:0] code;
  reg [4:0] size_log2;
  wire [20:0] mask;
  wire all_base;
  wire none_base;
  wire in_base;

  assign code = bp_i[2:0];

  always @*
  begin
    if (!bp_i[4])
      size_log2 = 5'd15 + {2'b00, code};
    else if (!code[2])
      size_log2 = 5'd11 + {2'b00, code};
    else
      size_log2 = 5'd15;
  end

  assign mask = ~((21'h000001 << size_log2) - 21'h000001);
  assign none_base = (code == 3'b000);
  assign all_base = (code[2:1] == 2'b11);
  // bp3 picks the low end, else the high end
  assign in_base = bp_i[3] ? ((addr_i & mask) == 21'h000000) : ((addr_i & mask) == mask);

  // complement inverts the whole map
  assign prot_o = cmp_i ^ (all_base | (!none_base & in_base));

endmodule // fsw_range_check

// ===== test/fsw_host_model.sv
// Purpose: spi host that sends command frames and polls busy
// Assumes: mode 0, sclk of 8 system clocks (160 ns)
// Notes: si inverted when released so a stale bit never looks valid
`timescale 1ns/1ps

module fsw_host_model
(
  input wire clock_i,
  input wire so_i,
  output reg sclk_o,
  output reg cs_n_o,
  output reg si_o
);
  // ==========================================
  // frame tasks
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
      begin
        si_o = tx[i];
        repeat (4) @(negedge clock_i);
        sclk_o = 1'b1;
        repeat (4) @(negedge clock_i);
        // sampled before the fall, the device shifts later
        rx[i] = so_i;
        sclk_o = 1'b0;
      end
    end
  endtask

  task stop;
    begin
      repeat (4) @(negedge clock_i);
      cs_n_o = 1'b1;
      si_o = ~si_o;
      repeat (8) @(negedge clock_i);
    end
  endtask

  task send(input [39:0] w, input integer nb);
    reg [7:0] r;
    integer b;
    begin
      cs_n_o = 1'b0;
      for (b = 0; b < nb; b = b + 1)
        xfer(w[39 - 8 * b -: 8], r);
      stop;
    end
  endtask

  task rd(input [7:0] c, output [7:0] r);
    begin
      cs_n_o = 1'b0;
      xfer(c, r);
      xfer(8'h00, r);
      stop;
    end
  endtask

  task poll(output ok);
    reg [7:0] r;
    integer n;
    begin
      cs_n_o = 1'b0;
      xfer(8'h05, r);
      r = 8'hff;
      n = 0;
      while (r[0] !== 1'b0 && n < 200)
      begin
        xfer(8'h00, r);
        n = n + 1;
      end
      stop;
      ok = (r[0] === 1'b0);
    end
  endtask
endmodule // fsw_host_model

// ===== test/fsw_protect_checker.sv
// Purpose: port-level assertions for the status word and protect block
// Assumes: busy counts of 16 cycles or more in simulation
// Notes: bound to every fsw_protect instance
`timescale 1ns/1ps

module fsw_protect_checker
(
  input wire clock_i,
  input wire arst_n_i,
  input wire cs_n_i,
  input wire so_oe_o,
  input wire [15:0] status_o,
  input wire busy_flag_o,
  input wire write_enable_latch_o,
  input wire security_lock_o,
  input wire array_go_o,
  input wire [1:0] array_op_o
);
  // ==========================================
  // relations between outputs and inputs
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);

  a_busy_mirror: assert property (busy_flag_o == status_o[0])
    else $error("busy port differs from status bit");
  a_wel_mirror: assert property (write_enable_latch_o == status_o[1])
    else $error("latch port differs from status bit");
  a_reserved_zero: assert property (status_o[12:11] == 2'h0)
    else $error("reserved status bits not zero");
  a_lock_sticky: assert property (security_lock_o |=> security_lock_o)
    else $error("security lock cleared");
  a_busy_clears_wel: assert property ($rose(busy_flag_o) |-> !write_enable_latch_o)
    else $error("latch still set once busy");
  a_busy_min_len: assert property ($rose(busy_flag_o) |-> busy_flag_o [*8])
    else $error("busy dropped early");
  a_go_in_busy: assert property (array_go_o |-> busy_flag_o ##1 !array_go_o)
    else $error("start pulse outside busy or too long");
  a_ce_guard: assert property (array_go_o && array_op_o == 2'h3 |-> status_o[4:2] == 3'h0 && !status_o[14])
    else $error("chip erase started while protected");
  a_so_released: assert property (cs_n_i [*3] |-> !so_oe_o)
    else $error("serial out driven while deselected");
endmodule // fsw_protect_checker

bind fsw_protect fsw_protect_checker u_chk
(
  .clock_i(clock_i),
  .arst_n_i(arst_n_i),
  .cs_n_i(cs_n_i),
  .so_oe_o(so_oe_o),
  .status_o(status_o),
  .busy_flag_o(busy_flag_o),
  .write_enable_latch_o(write_enable_latch_o),
  .security_lock_o(security_lock_o),
  .array_go_o(array_go_o),
  .array_op_o(array_op_o)
);

// ===== test/tb_fsw_protect.sv
// Purpose: self-checking bench for the status word and protect block
// Assumes: short busy counts set by parameters
// Notes: the host model drives every spi frame
`timescale 1ns/1ps

module tb_fsw_protect;
  reg clock_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg wp_n_i = 1'b0;
  wire sclk;
  wire cs_n;
  wire si;
  wire so;
  wire go;
  wire so_oe;
  wire qe;
  wire [1:0] aop;
  wire [20:0] aaddr;
  wire [15:0] st;
  reg [7:0] rb;
  integer err_total = 0;
  integer checks = 0;
  integer cyc = 0;
  integer gos = 0;
  integer g0;
  reg ok;

  // ==========================================
  // clock, timeout, instances
  always #10 clock_i = ~clock_i;

  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (go === 1'b1)
      gos <= gos + 1;
    if (cyc == 80000)
    begin
      err_total = err_total + 1;
      end_sim;
    end
  end

  // undriven so shows the inverse, so a missing enable cannot pass
  fsw_host_model h (.clock_i(clock_i), .so_i(so_oe ? so : ~so), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si));

  fsw_protect #(.SRW_CYCLES(24'h10), .PP_CYCLES(24'h20), .SE_CYCLES(24'h20), .BE_CYCLES(24'h100),
    .CE_CYCLES(24'h40)) dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .si_i(si), .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe), .status_o(st), .busy_flag_o(),
    .write_enable_latch_o(), .quad_enable_o(qe), .security_lock_o(), .array_go_o(go),
    .array_op_o(aop), .array_addr_o(aaddr));

  // ==========================================
  // tasks
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task rst;
    begin
      arst_n_i = 1'b0;
      repeat (3) @(negedge clock_i);
      arst_n_i = 1'b1;
      repeat (8) @(negedge clock_i);
    end
  endtask

  task sw(input [7:0] lo, input [7:0] hi);
    begin
      h.send(40'h0600000000, 1);
      h.send({8'h01, lo, hi, 16'h0000}, 3);
      h.poll(ok);
      chk({15'h0, ok}, 16'h0001);
    end
  endtask

  function [1:0] op_of(input [7:0] c);
    begin
      if (c == 8'h02)
        op_of = 2'h0;
      else if (c == 8'h20)
        op_of = 2'h1;
      else if (c == 8'h52 || c == 8'hd8)
        op_of = 2'h2;
      else
        op_of = 2'h3;
    end
  endfunction

  // sets protection, then one write-type frame; exp is whether it starts
  task op(input [4:0] bp, input cmp, input [39:0] fr, input integer nb, input exp);
    begin
      sw({1'b0, bp, 2'h0}, {1'b0, cmp, 6'h0});
      g0 = gos;
      h.send(40'h0600000000, 1);
      h.send(fr, nb);
      h.poll(ok);
      chk({15'h0, ok}, 16'h0001);
      chk(16'(gos - g0), {15'h0, exp});
      chk(st, {1'b0, cmp, 6'h0, 1'b0, bp, 2'h0});
      if (exp)
      begin
        chk({14'h0, aop}, {14'h0, op_of(fr[39:32])});
        if (nb > 1)
        begin
          chk({3'h0, aaddr[20:8]}, {3'h0, fr[28:16]});
          chk({8'h0, aaddr[7:0]}, {8'h0, fr[15:8]});
        end
      end
    end
  endtask

  task end_sim;
    begin
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  // ==========================================
  // sequence
  initial
  begin
    rst;
    chk(st, 16'h0000);
    h.send(40'h0600000000, 1);
    chk(st, 16'h0002);
    h.send(40'h0400000000, 1);
    chk(st, 16'h0000);
    h.send(40'ha300000000, 1);
    chk(st, 16'h2000);
    h.send(40'hab00000000, 1);
    chk(st, 16'h0000);
    g0 = gos;
    h.send(40'h2000000000, 4);
    h.poll(ok);
    chk({15'h0, ok}, 16'h0001);
    chk(16'(gos - g0), 16'h0000);
    // wp held low here, mode 00 must still accept writes
    op(5'h01, 1'b1, 40'h201f000000, 4, 1'b1);
    op(5'h01, 1'b1, 40'h201ef00000, 4, 1'b0);
    op(5'h09, 1'b1, 40'h2000000000, 4, 1'b1);
    op(5'h09, 1'b1, 40'h2001000000, 4, 1'b0);
    op(5'h09, 1'b1, 40'h5200800000, 4, 1'b1);
    op(5'h18, 1'b1, 40'h201ff00000, 4, 1'b0);
    op(5'h06, 1'b1, 40'hd800000000, 4, 1'b1);
    op(5'h11, 1'b1, 40'h201ff00000, 4, 1'b1);
    op(5'h11, 1'b1, 40'h201fe00000, 4, 1'b0);
    op(5'h19, 1'b1, 40'h2000000000, 4, 1'b1);
    op(5'h19, 1'b1, 40'h2000100000, 4, 1'b0);
    op(5'h01, 1'b0, 40'h021f000000, 5, 1'b0);
    op(5'h01, 1'b0, 40'h0200000000, 5, 1'b1);
    op(5'h06, 1'b1, 40'h6000000000, 1, 1'b0);
    op(5'h00, 1'b0, 40'h6000000000, 1, 1'b1);
    op(5'h00, 1'b0, 40'hc700000000, 1, 1'b1);
    // long block erase paused by suspend, continued by resume
    h.send(40'h0600000000, 1);
    h.send(40'hd800000000, 4);
    h.send(40'h7500000000, 1);
    chk(st, 16'h8000);
    h.send(40'h7a00000000, 1);
    chk(st, 16'h0001);
    h.poll(ok);
    chk({15'h0, ok}, 16'h0001);
    chk(st, 16'h0000);
    sw(8'h00, 8'h06);
    chk(st, 16'h0600);
    chk({15'h0, qe}, 16'h0001);
    sw(8'h00, 8'h00);
    chk(st, 16'h0400);
    chk({15'h0, qe}, 16'h0000);
    sw(8'h80, 8'h04);
    sw(8'h84, 8'h04);
    chk(st, 16'h0480);
    wp_n_i = 1'b1;
    sw(8'h84, 8'h04);
    chk(st, 16'h0484);
    h.rd(8'h05, rb);
    chk({8'h0, rb}, 16'h0084);
    h.rd(8'h35, rb);
    chk({8'h0, rb}, 16'h0004);
    sw(8'h00, 8'h05);
    sw(8'h00, 8'h04);
    chk(st, 16'h0500);
    rst;
    chk(st, 16'h0000);
    sw(8'h80, 8'h01);
    sw(8'h00, 8'h00);
    chk(st, 16'h0180);
    end_sim;
  end
endmodule // tb_fsw_protect
